// >>> rtl/mcs_cfg.svh
`ifndef MCS_CFG_SVH
`define MCS_CFG_SVH
// ----------------------------------------
// Register offsets (word addresses)
// ----------------------------------------
`define MCS_REG_CTRL 8'h00
`define MCS_REG_COMMON_TIME 8'h01
`define MCS_REG_STATUS 8'h02
`define MCS_REG_LOAD 8'h03
`define MCS_REG_WORK_BASE 8'h40
// ----------------------------------------
// Control field positions
// ----------------------------------------
`define MCS_CTRL_PIN_SEL 0
`define MCS_CTRL_SCREEN_START 1
`define MCS_CTRL_MAN_LO 4
`define MCS_CTRL_MAN_HI 7
`define MCS_CTRL_JUDGE_OK 8
// ----------------------------------------
// Per-work word layout
// ----------------------------------------
`define MCS_WK_START_LD 2'h0
`define MCS_WK_STOP_LD 2'h1
`define MCS_WK_MODE 2'h2
`define MCS_WK_TIMES 2'h3
`define MCS_MODE_START_LOAD 0
`define MCS_MODE_STOP_LO 1
`define MCS_MODE_STOP_HI 2
`define MCS_MODE_PER_JOB 3
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define MCS_COMMON_TIME_RST 10'd100
`define MCS_CLK_HZ 125000000
`define MCS_TICK_MS 100
`define MCS_PULSE_US 500
`define MCS_START_CLR_MS 1
`endif

// >>> rtl/mcs_pkg.sv
package mcs_pkg;
  typedef enum logic [1:0] {
    MCS_STOP_SIGNAL,
    MCS_STOP_LOAD,
    MCS_STOP_LOAD_ONLY,
    MCS_STOP_REPEAT
  } mcs_stop_t;
  typedef enum logic [1:0] {
    MCS_IDLE,
    MCS_MEASURE,
    MCS_WAIT
  } mcs_state_t;
endpackage : mcs_pkg

// >>> rtl/mcs_sequencer.sv
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "mcs_cfg.svh"
module mcs_sequencer #(
  parameter int LOAD_W = 16,
  parameter int TICK_CYCLES = (`MCS_CLK_HZ / 1000) * `MCS_TICK_MS,
  parameter int PULSE_CYCLES = (`MCS_CLK_HZ / 1000000) * `MCS_PULSE_US
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic pin_start_stop,
  input wire logic work_select_bit0,
  input wire logic work_select_bit1,
  input wire logic work_select_bit2,
  input wire logic work_select_bit3,
  input wire logic [LOAD_W-1:0] load_value,
  output logic measuring,
  output logic meas_done,
  output logic judge_done,
  output logic release_hold,
  output logic digital_zeroing_en,
  output logic card_record_en,
  output logic [3:0] active_work
);
  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  logic rst_m, rst_n;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] pin_m, pin_s;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_m <= 5'h00;
      pin_s <= 5'h00;
    end else if (clk_en) begin
      pin_m <= {pin_start_stop, work_select_bit3, work_select_bit2,
                work_select_bit1, work_select_bit0};
      pin_s <= pin_m;
    end
  end
  logic pin_run, pin_run_d;
  assign pin_run = pin_s[4];

  // ----------------------------------------
  // Registers and work store
  // ----------------------------------------
  localparam int START_CLR_CYCLES = (`MCS_CLK_HZ / 1000) * `MCS_START_CLR_MS;
  logic pin_sel, screen_start, judge_ok;
  logic [3:0] man_work;
  logic [9:0] common_time;
  logic [31:0] work_mem [0:63];
  mcs_pkg::mcs_state_t state;
  logic [3:0] cur_work;
  logic screen_d;

  function automatic logic exceeds(input logic [LOAD_W-1:0] a, input logic [LOAD_W-1:0] b);
    return a > b;
  endfunction : exceeds

  function automatic logic [3:0] work_of(input logic [3:0] bits);
    return bits; // code 0 is work 1, code 15 is work 16
  endfunction : work_of

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_sel <= 1'b0;
      screen_start <= 1'b0;
      man_work <= 4'h0;
      judge_ok <= 1'b0;
      common_time <= `MCS_COMMON_TIME_RST;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == `MCS_REG_CTRL) begin
        pin_sel <= reg_wdata[`MCS_CTRL_PIN_SEL];
        screen_start <= reg_wdata[`MCS_CTRL_SCREEN_START];
        man_work <= reg_wdata[`MCS_CTRL_MAN_HI:`MCS_CTRL_MAN_LO];
        judge_ok <= reg_wdata[`MCS_CTRL_JUDGE_OK];
      end else if (reg_addr == `MCS_REG_COMMON_TIME) begin
        common_time <= reg_wdata[9:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clk_en && reg_wr && reg_addr[7:6] == 2'b01) begin
      work_mem[reg_addr[5:0]] <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      if (reg_rd) begin
        case (reg_addr)
          `MCS_REG_CTRL: reg_rdata <= {23'h0, judge_ok, man_work, 2'h0, screen_start, pin_sel};
          `MCS_REG_COMMON_TIME: reg_rdata <= {22'h0, common_time};
          `MCS_REG_STATUS: reg_rdata <= {26'h0, state, cur_work};
          `MCS_REG_LOAD: reg_rdata <= 32'(load_value);
          default: reg_rdata <= (reg_addr[7:6] == 2'b01) ? work_mem[reg_addr[5:0]] : 32'h0;
        endcase
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // Active work fields
  // ----------------------------------------
  logic [3:0] sel_work;
  logic [31:0] w_start, w_stop, w_mode, w_times;
  logic [LOAD_W-1:0] start_ld, stop_ld;
  mcs_pkg::mcs_stop_t stop_mode;
  logic [9:0] meas_time, wait_time;
  assign sel_work = pin_sel ? work_of(pin_s[3:0]) : man_work;
  assign w_start = work_mem[{cur_work, `MCS_WK_START_LD}];
  assign w_stop = work_mem[{cur_work, `MCS_WK_STOP_LD}];
  assign w_mode = work_mem[{cur_work, `MCS_WK_MODE}];
  assign w_times = work_mem[{cur_work, `MCS_WK_TIMES}];
  assign start_ld = w_start[LOAD_W-1:0];
  assign stop_ld = w_stop[LOAD_W-1:0];
  assign stop_mode = mcs_pkg::mcs_stop_t'({w_mode[`MCS_MODE_STOP_HI], w_mode[`MCS_MODE_STOP_LO]});
  assign meas_time = w_mode[`MCS_MODE_PER_JOB] ? w_times[9:0] : common_time;
  assign wait_time = w_times[25:16];

  // ----------------------------------------
  // Start and stop decisions
  // ----------------------------------------
  logic screen_rise, start_req, start_ok, load_stop, reached, time_up, pin_fall, stop_now;
  logic [31:0] tick_cnt;
  logic [9:0] tenths;
  assign screen_rise = screen_start & ~screen_d;
  assign pin_fall = pin_run_d & ~pin_run;
  assign start_req = screen_rise | (pin_run & ~pin_run_d);
  assign start_ok = ~w_mode[`MCS_MODE_START_LOAD] | exceeds(load_value, start_ld);
  assign time_up = (tenths >= meas_time) && (tick_cnt == 32'(TICK_CYCLES - 1));
  always_comb begin
    if (start_ld <= stop_ld) begin
      load_stop = exceeds(load_value, start_ld) && exceeds(load_value, stop_ld);
    end else begin
      load_stop = reached && (load_value <= stop_ld);
    end
  end
  always_comb begin
    case (stop_mode)
      mcs_pkg::MCS_STOP_SIGNAL: stop_now = time_up | pin_fall;
      mcs_pkg::MCS_STOP_LOAD: stop_now = time_up | pin_fall | load_stop;
      mcs_pkg::MCS_STOP_LOAD_ONLY: stop_now = time_up | load_stop;
      mcs_pkg::MCS_STOP_REPEAT: stop_now = time_up;
      default: stop_now = time_up;
    endcase
  end
  logic repeat_end;
  logic from_screen;
  assign repeat_end = from_screen ? screen_rise : pin_fall;

  // ----------------------------------------
  // Edge history
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      screen_d <= 1'b0;
      pin_run_d <= 1'b0;
    end else if (clk_en) begin
      screen_d <= screen_start;
      pin_run_d <= pin_run;
    end
  end

  // ----------------------------------------
  // Pin start request
  // ----------------------------------------
  // Armed by a pin rising edge and used once,
  // so a pin left high after a stop cannot restart
  logic pin_armed, start_go, start_taken;
  assign start_go = (start_req || pin_armed || (from_screen && screen_start)) && start_ok;
  assign start_taken = (state == mcs_pkg::MCS_IDLE) && start_go;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_armed <= 1'b0;
    end else if (clk_en) begin
      if (pin_fall || start_taken) begin
        pin_armed <= 1'b0;
      end else if (pin_run && !pin_run_d) begin
        pin_armed <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  // Zeroing and recording both off while a repeat runs
  logic repeat_run;
  assign repeat_run = (state != mcs_pkg::MCS_IDLE) && (stop_mode == mcs_pkg::MCS_STOP_REPEAT);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      digital_zeroing_en <= 1'b1;
      card_record_en <= 1'b1;
      active_work <= 4'h0;
      release_hold <= 1'b0;
    end else if (clk_en) begin
      active_work <= cur_work;
      release_hold <= clr_cnt != 32'h0;
      digital_zeroing_en <= !repeat_run;
      card_record_en <= !repeat_run;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic [31:0] pulse_cnt;
  logic [31:0] clr_cnt;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= mcs_pkg::MCS_IDLE;
      cur_work <= 4'h0;
      from_screen <= 1'b0;
      reached <= 1'b0;
      tick_cnt <= 32'h0;
      tenths <= 10'h0;
      measuring <= 1'b0;
      meas_done <= 1'b0;
      judge_done <= 1'b0;
      pulse_cnt <= 32'h0;
      clr_cnt <= 32'h0;
    end else if (clk_en) begin
      // Hold release window after each start
      if (clr_cnt != 32'h0) begin
        clr_cnt <= clr_cnt - 32'h1;
      end
      if (pulse_cnt != 32'h0) begin
        pulse_cnt <= pulse_cnt - 32'h1;
        if (pulse_cnt == 32'h1) begin
          meas_done <= 1'b0;
          judge_done <= 1'b0;
        end
      end
      if (state == mcs_pkg::MCS_IDLE) begin
        cur_work <= sel_work;
      end
      if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
        tick_cnt <= 32'h0;
        tenths <= tenths + 10'h1;
      end else begin
        tick_cnt <= tick_cnt + 32'h1;
      end
      case (state)
        mcs_pkg::MCS_IDLE: begin
          if (start_req) begin
            from_screen <= screen_rise;
          end
          if (start_go) begin
            state <= mcs_pkg::MCS_MEASURE;
            measuring <= 1'b1;
            meas_done <= 1'b0;
            judge_done <= 1'b0;
            clr_cnt <= 32'(START_CLR_CYCLES);
            tick_cnt <= 32'h0;
            tenths <= 10'h1;
            reached <= 1'b0;
          end
        end
        mcs_pkg::MCS_MEASURE: begin
          if (load_value >= start_ld) begin
            reached <= 1'b1;
          end
          if (stop_mode == mcs_pkg::MCS_STOP_REPEAT && repeat_end) begin
            state <= mcs_pkg::MCS_IDLE;
            measuring <= 1'b0;
            from_screen <= 1'b0;
          end else if (stop_now) begin
            measuring <= 1'b0;
            meas_done <= 1'b1;
            judge_done <= judge_ok;
            if (stop_mode == mcs_pkg::MCS_STOP_REPEAT) begin
              cur_work <= sel_work;
              tick_cnt <= 32'h0;
              tenths <= 10'h1;
              if (wait_time == 10'h0) begin
                pulse_cnt <= 32'(PULSE_CYCLES);
                state <= mcs_pkg::MCS_WAIT;
              end else begin
                state <= mcs_pkg::MCS_WAIT;
              end
            end else begin
              state <= mcs_pkg::MCS_IDLE;
              from_screen <= 1'b0;
            end
          end
        end
        mcs_pkg::MCS_WAIT: begin
          if (repeat_end) begin
            state <= mcs_pkg::MCS_IDLE;
            from_screen <= 1'b0;
          end else if (tenths > wait_time && pulse_cnt <= 32'h1) begin
            state <= mcs_pkg::MCS_MEASURE;
            measuring <= 1'b1;
            meas_done <= 1'b0;
            judge_done <= 1'b0;
            pulse_cnt <= 32'h0;
            clr_cnt <= 32'(START_CLR_CYCLES);
            tick_cnt <= 32'h0;
            tenths <= 10'h1;
            reached <= 1'b0;
          end
        end
        default: state <= mcs_pkg::MCS_IDLE;
      endcase
    end
  end
endmodule : mcs_sequencer

// >>> dv/mcs_sequencer_assertions.sv
`timescale 1ns/1ps
module mcs_seq_chk #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic measuring,
  input wire logic meas_done,
  input wire logic judge_done,
  input wire logic digital_zeroing_en,
  input wire logic card_record_en,
  input wire logic [3:0] active_work
);
  // ----
  // Length of one single measurement
  // ----
  int run_len;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      run_len <= 0;
    end else if (clk_en) begin
      run_len <= (measuring && digital_zeroing_en) ? run_len + 1 : 0;
    end
  end
  AST_RDATA_IDLE: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  AST_WORK_HELD: assert property (measuring && $past(measuring) && digital_zeroing_en |-> $stable(active_work))
    else $error("work changed mid measurement");
  AST_START_CLEARS: assert property ($rose(measuring) && digital_zeroing_en |-> ##[0:4] (!meas_done && !judge_done))
    else $error("outputs not cleared at start");
  AST_DONE_AFTER: assert property ($rose(meas_done) |-> $past(measuring))
    else $error("done without measurement");
  AST_JUDGE_DONE: assert property ($rose(judge_done) |-> meas_done)
    else $error("judged without done");
  AST_REPEAT_OFF: assert property (digital_zeroing_en == card_record_en)
    else $error("zeroing and recording differ");
  AST_TIME_BOUND: assert property (run_len <= 999 * TICK_CYCLES + 8)
    else $error("measurement too long");
  AST_FREEZE: assert property (!clk_en |=> $stable(measuring) && $stable(meas_done))
    else $error("state moved while frozen");
endmodule : mcs_seq_chk
bind mcs_sequencer mcs_seq_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk_sys(clk_sys),
  .arst_n(arst_n), .clk_en(clk_en), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .measuring(measuring), .meas_done(meas_done), .judge_done(judge_done),
  .digital_zeroing_en(digital_zeroing_en), .card_record_en(card_record_en),
  .active_work(active_work));

// >>> dv/mcs_ctrl_model.sv
`timescale 1ns/1ps
module mcs_ctrl_model (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [3:0] code,
  output logic pin_start_stop,
  output logic [3:0] sel
);
  // ----
  // Pins move just after an edge
  // ----
  initial pin_start_stop = 1'b0;
  initial sel = 4'h0;
  always @(posedge clk_sys) begin
    pin_start_stop <= go;
    sel <= code;
  end
endmodule : mcs_ctrl_model

// >>> dv/mcs_sequencer_test.sv
`timescale 1ns/1ps
`include "mcs_cfg.svh"
module mcs_sequencer_test;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] load_value = 16'h0;
  logic go = 1'b0;
  logic [3:0] code = 4'h0;
  logic pend = 1'b0;
  logic [31:0] reg_rdata;
  logic pin_start_stop, measuring, meas_done, judge_done, dz_en, rec_en;
  logic [3:0] sel, active_work, w;
  logic [31:0] expq[$];
  int errors = 0;
  int n_tests = 0;
  int seed = 32'hf181a282;
  int n;
  always #4 clk_sys = ~clk_sys;
  mcs_ctrl_model u_ctrl (.clk_sys(clk_sys), .go(go), .code(code),
    .pin_start_stop(pin_start_stop), .sel(sel));
  mcs_sequencer #(.TICK_CYCLES(10), .PULSE_CYCLES(4)) DUT (.clk_sys(clk_sys),
    .arst_n(arst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_start_stop(pin_start_stop), .work_select_bit0(sel[0]),
    .work_select_bit1(sel[1]), .work_select_bit2(sel[2]), .work_select_bit3(sel[3]),
    .load_value(load_value), .measuring(measuring), .meas_done(meas_done),
    .judge_done(judge_done), .release_hold(), .digital_zeroing_en(dz_en),
    .card_record_en(rec_en), .active_work(active_work));
  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic cfg(input logic [3:0] k, input logic [31:0] md, tm, s, p);
    logic [7:0] a;
    a = 8'(`MCS_REG_WORK_BASE + 4 * k);
    wr(a, s);
    wr(a + 8'h01, p);
    wr(a + 8'h02, md);
    wr(a + 8'h03, tm);
  endtask : cfg
  task automatic wt(input logic s, input logic v, input int lim);
    n = 0;
    while (((s ? meas_done : measuring) !== v) && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wt
  task automatic start(input logic [3:0] k);
    code <= k;
    repeat (4) @(posedge clk_sys);
    go <= 1'b1;
    wt(0, 1'b1, 12);
    chk(measuring, 1'b1);
  endtask : start
  always @(posedge clk_sys) begin
    if (pend) chk(reg_rdata, expq.pop_front());
    pend <= reg_rd;
  end
  initial begin
    #100000;
    errors++;
    complete_run();
  end
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    clk_en <= 1'b0;
    repeat (3) @(posedge clk_sys);
    clk_en <= 1'b1;
    chk({dz_en, rec_en}, 2'b11);
    rd(`MCS_REG_COMMON_TIME, 32'd100);
    rd(8'h0F, 32'h0);
    wr(`MCS_REG_CTRL, 32'h101);
    w = 4'($random(seed));
    cfg(w, 32'h8, 32'h3, 32'h0, 32'h0);
    rd(8'(`MCS_REG_WORK_BASE + 4 * w + 3), 32'h3);
    start(w);
    chk(active_work, w);
    code <= ~w;
    repeat (10) @(posedge clk_sys);
    chk(active_work, w);
    wt(0, 1'b0, 40);
    chk(n + 10 inside {[21:32]}, 1'b1);
    go <= 1'b0;
    cfg(4'h2, 32'h0, 32'h0, 32'h0, 32'h0);
    start(4'h2);
    go <= 1'b0;
    wt(0, 1'b0, 10);
    repeat (2) @(posedge clk_sys);
    chk({measuring, meas_done, judge_done}, 3'b011);
    cfg(4'h3, 32'hC, 32'h2, 32'd1000, 32'd2000);
    start(4'h3);
    go <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk(measuring, 1'b1);
    wt(0, 1'b0, 20);
    chk(measuring, 1'b0);
    cfg(4'h4, 32'h3, 32'h0, 32'd100, 32'd200);
    code <= 4'h4;
    repeat (4) @(posedge clk_sys);
    go <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk(measuring, 1'b0);
    load_value <= 16'd150;
    wt(0, 1'b1, 8);
    repeat (5) @(posedge clk_sys);
    chk(measuring, 1'b1);
    load_value <= 16'd250;
    wt(0, 1'b0, 8);
    chk(measuring, 1'b0);
    go <= 1'b0;
    load_value <= 16'd150;
    cfg(4'h5, 32'h2, 32'h0, 32'd200, 32'd100);
    start(4'h5);
    load_value <= 16'd250;
    repeat (5) @(posedge clk_sys);
    load_value <= 16'd150;
    repeat (5) @(posedge clk_sys);
    chk(measuring, 1'b1);
    load_value <= 16'd50;
    wt(0, 1'b0, 8);
    chk(measuring, 1'b0);
    go <= 1'b0;
    load_value <= 16'd0;
    cfg(4'h6, 32'hE, 32'h2, 32'h0, 32'h0);
    cfg(4'h7, 32'hE, 32'h0001_0003, 32'h0, 32'h0);
    start(4'h6);
    @(posedge clk_sys);
    chk({dz_en, rec_en}, 2'b00);
    code <= 4'h7;
    wt(1, 1'b1, 30);
    wt(1, 1'b0, 10);
    chk(n, 4);
    chk(active_work, 4'h7);
    wt(0, 1'b1, 20);
    wt(0, 1'b0, 40);
    chk(meas_done, 1'b1);
    wt(0, 1'b1, 20);
    chk(n inside {[1:14]}, 1'b1);
    go <= 1'b0;
    wt(0, 1'b0, 30);
    chk(measuring, 1'b0);
    repeat (6) @(posedge clk_sys);
    chk({dz_en, rec_en}, 2'b11);
    complete_run();
  end
endmodule : mcs_sequencer_test
